/* File: core/fspc_pkg.sv */
// Constants, register map and state codes of the flash self-program controller
package fspc_pkg;
  localparam int unsigned AXI_AW = 8;
  localparam int unsigned AXI_DW = 32;
  localparam int unsigned FLASH_AW = 15;
  localparam int unsigned FLASH_DW = 14;
  localparam int unsigned ROW_BITS = 5;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned ADDR_HIGH_W = FLASH_AW - BYTE_W;
  localparam int unsigned DATA_HIGH_W = FLASH_DW - BYTE_W;
  localparam int unsigned CTL_W = 7;

  localparam logic [AXI_AW-1:0] OFS_ADDR_LOW = 8'h00;
  localparam logic [AXI_AW-1:0] OFS_ADDR_HIGH = 8'h04;
  localparam logic [AXI_AW-1:0] OFS_DATA_LOW = 8'h08;
  localparam logic [AXI_AW-1:0] OFS_DATA_HIGH = 8'h0C;
  localparam logic [AXI_AW-1:0] OFS_CONTROL = 8'h10;
  localparam logic [AXI_AW-1:0] OFS_KEY = 8'h14;

  localparam int unsigned CTL_FETCH = 0;
  localparam int unsigned CTL_GO = 1;
  localparam int unsigned CTL_PERMIT = 2;
  localparam int unsigned CTL_ABORT = 3;
  localparam int unsigned CTL_ERASE = 4;
  localparam int unsigned CTL_LATCH = 5;
  localparam int unsigned CTL_CFGSEL = 6;

  localparam logic [BYTE_W-1:0] KEY_FIRST = 8'h55;
  localparam logic [BYTE_W-1:0] KEY_SECOND = 8'hAA;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam int unsigned PROG_TIME_US = 2000;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned PROG_CYCLES_DFLT = PROG_TIME_US * 1000 / CLK_PERIOD_NS;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_RD_WAIT = 6'h02,
    ST_RD_ARRAY = 6'h04,
    ST_PG_NOP1 = 6'h08,
    ST_PG_NOP2 = 6'h10,
    ST_PG_BUSY = 6'h20
  } fspc_state_t;

  typedef enum logic [2:0] {
    KEY_NONE = 3'h1,
    KEY_GOT_FIRST = 3'h2,
    KEY_ARMED = 3'h4
  } fspc_key_t;
endpackage : fspc_pkg

/* File: core/fspc_top.sv */
// Flash self-program controller: AXI4-Lite register file, read, unlock and row operations
// How it works
// [R01] Software loads address, clears space select, sets fetch
// [R02] Second slot after fetch is the array read
// [R03] Read word lands in data pair next cycle
// [R04] Data pair holds until read or write
// [R05] Software puts two NOPs after fetch
// [R06] Erase, latch, program need completed unlock first
// [R07] Unlock: key 55h, key AAh, go, NOPs
// [R08] Go forces next two slots to NOP
// [R09] Erase or program row stalls until done
// [R10] Latch load forces NOPs, never stalls
// [R11] Software masks interrupts around unlock sequence
// [R12] Erase takes whole row of given address
// [R13] Software erase order: address, select, keys, go
// [R14] Two preparation slots precede the erase
// [R15] Execution halts for erase time, clocks run
// [R16] Execution resumes at third instruction after go
// [R17] Hardware clears fetch and go on completion
// [R18] Modify only with permit set; reset clears it
// [R19] Reset during write sets abort flag
// [R20] Key port always reads as zero
// [R21] Broken key sequence makes go ignored
`timescale 1ns/1ps
module fspc_top #(
  parameter int unsigned PROG_CYCLES = fspc_pkg::PROG_CYCLES_DFLT
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic por_resetn_i,
  input wire logic [fspc_pkg::AXI_AW-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [fspc_pkg::AXI_DW-1:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [fspc_pkg::AXI_AW-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [fspc_pkg::AXI_DW-1:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic force_nop_o,
  output logic stall_o,
  output logic [fspc_pkg::FLASH_AW-1:0] arr_addr_o,
  output logic arr_rd_o,
  input wire logic [fspc_pkg::FLASH_DW-1:0] arr_rdata_i,
  output logic arr_erase_o,
  output logic arr_prog_o,
  output logic arr_latch_o,
  output logic arr_cfg_sel_o,
  output logic [fspc_pkg::FLASH_DW-1:0] arr_wdata_o
);
  import fspc_pkg::*;

  function automatic logic fspc_mapped(input logic [AXI_AW-1:0] a);
    fspc_mapped = (a == OFS_ADDR_LOW) || (a == OFS_ADDR_HIGH) || (a == OFS_DATA_LOW) ||
                  (a == OFS_DATA_HIGH) || (a == OFS_CONTROL) || (a == OFS_KEY);
  endfunction : fspc_mapped

  logic rst;
  logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [AXI_DW-1:0] rdata_reg, w_data_reg;
  logic [AXI_AW-1:0] aw_addr_reg;
  logic [3:0] w_strb_reg;
  logic wr_fire, wr_lo, ctl_wr, fetch_start, pg_start;
  logic [BYTE_W-1:0] addr_low_reg, data_low_reg;
  logic [ADDR_HIGH_W-1:0] addr_high_reg;
  logic [DATA_HIGH_W-1:0] data_high_reg;
  logic fetch_reg, go_reg, permit_reg, abort_reg, erase_sel_reg, latch_sel_reg, cfg_sel_reg;
  logic op_erase_reg, op_latch_reg;
  logic [CTL_W-1:0] ctl_view;
  fspc_key_t key_reg;
  fspc_state_t state_reg, state_next;
  logic [31:0] cnt_reg;
  logic force_nop_reg, arr_erase_reg, arr_prog_reg, arr_latch_reg;
  logic [FLASH_AW-1:0] arr_addr_reg;

  assign rst = !resetn_i || !por_resetn_i;
  assign wr_fire = !awready_reg && !wready_reg && !bvalid_reg;
  assign wr_lo = wr_fire && w_strb_reg[0];
  assign ctl_wr = wr_lo && (aw_addr_reg == OFS_CONTROL);
  assign pg_start = ctl_wr && w_data_reg[CTL_GO] && (state_reg == ST_IDLE) &&
                    (key_reg == KEY_ARMED) && permit_reg; // R06 R18 R21
  assign fetch_start = ctl_wr && w_data_reg[CTL_FETCH] && (state_reg == ST_IDLE) &&
                       !pg_start; // R01
  assign ctl_view = {cfg_sel_reg, latch_sel_reg, erase_sel_reg, abort_reg,
                     permit_reg, go_reg, fetch_reg};

  // Write channel: address and data taken in either order
  always_ff @(posedge mclk_i) begin
    if (rst) begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      aw_addr_reg <= '0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
    end else begin
      if (s_axi_awvalid_i && awready_reg) begin
        awready_reg <= 1'b0;
        aw_addr_reg <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && wready_reg) begin
        wready_reg <= 1'b0;
        w_data_reg <= s_axi_wdata_i;
        w_strb_reg <= s_axi_wstrb_i;
      end
      if (wr_fire) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= fspc_mapped(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_reg && s_axi_bready_i) begin
        bvalid_reg <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg <= 1'b1;
      end
    end
  end

  // Read channel, answer one cycle after the address is taken
  always_ff @(posedge mclk_i) begin
    if (rst) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
    end else if (s_axi_arvalid_i && arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rresp_reg <= fspc_mapped(s_axi_araddr_i) ? RESP_OKAY : RESP_SLVERR;
      unique case (s_axi_araddr_i)
        OFS_ADDR_LOW: rdata_reg <= AXI_DW'(addr_low_reg);
        OFS_ADDR_HIGH: rdata_reg <= AXI_DW'(addr_high_reg);
        OFS_DATA_LOW: rdata_reg <= AXI_DW'(data_low_reg);
        OFS_DATA_HIGH: rdata_reg <= AXI_DW'(data_high_reg);
        OFS_CONTROL: rdata_reg <= AXI_DW'(ctl_view);
        default: rdata_reg <= '0; // R20
      endcase
    end else if (rvalid_reg && s_axi_rready_i) begin
      rvalid_reg <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  // Address pair
  always_ff @(posedge mclk_i) begin
    if (rst) begin
      addr_low_reg <= '0;
      addr_high_reg <= '0;
    end else begin
      if (wr_lo && (aw_addr_reg == OFS_ADDR_LOW)) begin
        addr_low_reg <= w_data_reg[BYTE_W-1:0];
      end
      if (wr_lo && (aw_addr_reg == OFS_ADDR_HIGH)) begin
        addr_high_reg <= w_data_reg[ADDR_HIGH_W-1:0];
      end
    end
  end

  // Data pair; a finishing read overrides a software write in the same cycle
  always_ff @(posedge mclk_i) begin
    if (rst) begin
      data_low_reg <= '0;
      data_high_reg <= '0;
    end else if (state_reg == ST_RD_ARRAY) begin
      data_low_reg <= arr_rdata_i[BYTE_W-1:0]; // R03
      data_high_reg <= arr_rdata_i[FLASH_DW-1:BYTE_W]; // R03
    end else begin
      if (wr_lo && (aw_addr_reg == OFS_DATA_LOW)) begin
        data_low_reg <= w_data_reg[BYTE_W-1:0]; // R04
      end
      if (wr_lo && (aw_addr_reg == OFS_DATA_HIGH)) begin
        data_high_reg <= w_data_reg[DATA_HIGH_W-1:0]; // R04
      end
    end
  end

  // Unlock tracker: any other write in between disarms it
  always_ff @(posedge mclk_i) begin
    if (rst) begin
      key_reg <= KEY_NONE;
    end else if (wr_fire) begin
      if (wr_lo && (aw_addr_reg == OFS_KEY)) begin
        if (w_data_reg[BYTE_W-1:0] == KEY_FIRST) begin
          key_reg <= KEY_GOT_FIRST; // R07
        end else if ((key_reg == KEY_GOT_FIRST) && (w_data_reg[BYTE_W-1:0] == KEY_SECOND)) begin
          key_reg <= KEY_ARMED; // R07
        end else begin
          key_reg <= KEY_NONE; // R21
        end
      end else begin
        key_reg <= KEY_NONE; // R21
      end
    end
  end

  // Control bits; fetch and go are set-only for software
  always_ff @(posedge mclk_i) begin
    if (rst) begin
      fetch_reg <= 1'b0;
      go_reg <= 1'b0;
      permit_reg <= 1'b0; // R18
      erase_sel_reg <= 1'b0;
      latch_sel_reg <= 1'b0;
      cfg_sel_reg <= 1'b0;
      op_erase_reg <= 1'b0;
      op_latch_reg <= 1'b0;
    end else begin
      if (ctl_wr) begin
        permit_reg <= w_data_reg[CTL_PERMIT];
        erase_sel_reg <= w_data_reg[CTL_ERASE];
        latch_sel_reg <= w_data_reg[CTL_LATCH];
        cfg_sel_reg <= w_data_reg[CTL_CFGSEL];
      end
      if (fetch_start) begin
        fetch_reg <= 1'b1;
      end else if (state_reg == ST_RD_ARRAY) begin
        fetch_reg <= 1'b0; // R17
      end
      if (pg_start) begin
        go_reg <= 1'b1;
        op_erase_reg <= w_data_reg[CTL_ERASE];
        op_latch_reg <= w_data_reg[CTL_LATCH] && !w_data_reg[CTL_ERASE];
      end else if ((state_reg == ST_PG_NOP2 && op_latch_reg) || state_next == ST_IDLE) begin
        go_reg <= 1'b0; // R17
      end
    end
  end

  // Abort flag survives the ordinary reset; power-up or a control write with abort at 0 clears it
  always_ff @(posedge mclk_i) begin
    if (!por_resetn_i) begin
      abort_reg <= 1'b0;
    end else if (!resetn_i) begin
      if (state_reg == ST_PG_BUSY) begin
        abort_reg <= 1'b1; // R19
      end
    end else if (ctl_wr && !w_data_reg[CTL_ABORT]) begin
      abort_reg <= 1'b0;
    end
  end

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (pg_start) begin
          state_next = ST_PG_NOP1;
        end else if (fetch_start) begin
          state_next = ST_RD_WAIT;
        end
      end
      ST_RD_WAIT: state_next = ST_RD_ARRAY; // R02
      ST_RD_ARRAY: state_next = ST_IDLE;
      ST_PG_NOP1: state_next = ST_PG_NOP2; // R08 R14
      ST_PG_NOP2: state_next = op_latch_reg ? ST_IDLE : ST_PG_BUSY; // R09 R10
      ST_PG_BUSY: begin
        if (cnt_reg == 32'(PROG_CYCLES - 1)) begin
          state_next = ST_IDLE; // R16
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      force_nop_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      force_nop_reg <= (state_next == ST_RD_ARRAY) || (state_next == ST_PG_NOP1) ||
                       (state_next == ST_PG_NOP2); // R02 R08
    end
  end

  // Busy timer; clocks keep running, only the core is held
  always_ff @(posedge mclk_i) begin
    if (rst) begin
      cnt_reg <= '0;
    end else if (state_reg == ST_PG_BUSY) begin
      cnt_reg <= cnt_reg + 32'h00000001; // R15
    end else begin
      cnt_reg <= '0;
    end
  end

  // One-cycle array strobes as the two forced slots end
  always_ff @(posedge mclk_i) begin
    if (rst) begin
      arr_erase_reg <= 1'b0;
      arr_prog_reg <= 1'b0;
      arr_latch_reg <= 1'b0;
    end else begin
      arr_erase_reg <= (state_reg == ST_PG_NOP2) && op_erase_reg; // R06
      arr_prog_reg <= (state_reg == ST_PG_NOP2) && !op_erase_reg && !op_latch_reg; // R06
      arr_latch_reg <= (state_reg == ST_PG_NOP2) && op_latch_reg; // R10
    end
  end

  // Row alignment only while an erase runs, so a later read still hits its word
  always_ff @(posedge mclk_i) begin
    if (rst) begin
      arr_addr_reg <= '0;
    end else if (op_erase_reg && (state_reg == ST_PG_NOP1 || state_reg == ST_PG_NOP2 ||
                                  state_reg == ST_PG_BUSY)) begin
      arr_addr_reg <= {addr_high_reg, addr_low_reg[BYTE_W-1:ROW_BITS], {ROW_BITS{1'b0}}}; // R12
    end else begin
      arr_addr_reg <= {addr_high_reg, addr_low_reg};
    end
  end

  assign s_axi_awready_o = awready_reg;
  assign s_axi_wready_o = wready_reg;
  assign s_axi_bvalid_o = bvalid_reg;
  assign s_axi_bresp_o = bresp_reg;
  assign s_axi_arready_o = arready_reg;
  assign s_axi_rvalid_o = rvalid_reg;
  assign s_axi_rdata_o = rdata_reg;
  assign s_axi_rresp_o = rresp_reg;
  assign force_nop_o = force_nop_reg;
  assign stall_o = state_reg[5];
  assign arr_addr_o = arr_addr_reg;
  assign arr_rd_o = state_reg[2];
  assign arr_erase_o = arr_erase_reg;
  assign arr_prog_o = arr_prog_reg;
  assign arr_latch_o = arr_latch_reg;
  assign arr_cfg_sel_o = cfg_sel_reg;
  assign arr_wdata_o = {data_high_reg, data_low_reg};

  logic [31:0] stall_len_reg;
  always_ff @(posedge mclk_i) begin
    if (rst) begin
      stall_len_reg <= '0;
    end else begin
      stall_len_reg <= stall_o ? stall_len_reg + 32'h00000001 : '0;
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst);

  read_slot_a: assert property (fetch_start |=> !arr_rd_o ##1 (arr_rd_o && force_nop_o)) // R02
    else $error("array read not in second slot");
  read_data_a: assert property (arr_rd_o |=> ({data_high_reg, data_low_reg} ==
                                $past(arr_rdata_i))) // R03
    else $error("read word not captured");
  data_hold_a: assert property ((!arr_rd_o && !(wr_lo && aw_addr_reg == OFS_DATA_LOW))
                                |=> $stable(data_low_reg)) // R04
    else $error("data low changed without cause");
  nop_pair_a: assert property (pg_start |=> force_nop_o [*2]) // R08
    else $error("go did not force two NOPs");
  stall_len_a: assert property ($fell(stall_o) && !$past(rst) |-> stall_len_reg == PROG_CYCLES) // R09
    else $error("stall length wrong");
  latch_nostall_a: assert property ((pg_start && w_data_reg[CTL_LATCH] && !w_data_reg[CTL_ERASE])
                                    |=> !stall_o [*4]) // R10
    else $error("latch load stalled");
  erase_row_a: assert property (arr_erase_o |-> arr_addr_o[ROW_BITS-1:0] == '0) // R12
    else $error("erase address not row aligned");
  resume_a: assert property ($fell(stall_o) |-> !force_nop_o && !go_reg) // R16
    else $error("resume not clean");
  bits_clear_a: assert property (state_reg == ST_IDLE |-> !fetch_reg && !go_reg) // R17
    else $error("fetch or go left set");
  start_cause_a: assert property (state_reg == ST_PG_NOP1 |->
                                  $past(permit_reg) && ($past(key_reg) == KEY_ARMED)) // R18
    else $error("modify started without unlock");
  key_zero_a: assert property ((s_axi_arvalid_i && arready_reg && s_axi_araddr_i == OFS_KEY)
                               |=> rdata_reg == '0) // R20
    else $error("key port read nonzero");
  abort_set_a: assert property (@(posedge mclk_i) disable iff (!por_resetn_i)
                                (!resetn_i && state_reg == ST_PG_BUSY) |=> abort_reg) // R19
    else $error("abort flag not set");

  read_c: cover property (fetch_start ##3 state_reg == ST_IDLE);
  erase_c: cover property (arr_erase_o ##1 stall_o);
  latch_c: cover property (arr_latch_o);
  program_c: cover property (arr_prog_o);
endmodule : fspc_top

/* File: dv/fspc_array_model.sv */
// Flash array stand-in answering read strobes with an address-derived word
`timescale 1ns/1ps
module fspc_array_model
  import fspc_pkg::*;
(
  input wire logic mclk_i,
  input wire logic [fspc_pkg::FLASH_AW-1:0] arr_addr_i,
  input wire logic arr_rd_i,
  output logic [fspc_pkg::FLASH_DW-1:0] arr_rdata_o
);
  logic [FLASH_DW-1:0] junk_reg = 14'h0000;
  // Outside the strobe the word churns, so a late capture cannot pass by luck
  always_ff @(posedge mclk_i) begin
    junk_reg <= ~junk_reg ^ 14'h0155;
  end
  assign arr_rdata_o = arr_rd_i ? (arr_addr_i[13:0] ^ 14'h2C3A) : junk_reg;
endmodule : fspc_array_model

/* File: dv/test_flash_self_program_ctrl.sv */
// Self-checking bench of the flash self-program controller
`timescale 1ns/1ps
module test_flash_self_program_ctrl;
  import fspc_pkg::*;
  localparam int unsigned PC = 8;
  localparam logic [31:0] FETCH = 32'h1 << CTL_FETCH;
  localparam logic [31:0] GO = 32'h1 << CTL_GO;
  localparam logic [31:0] PERMIT = 32'h1 << CTL_PERMIT;
  localparam logic [31:0] ABORT = 32'h1 << CTL_ABORT;
  localparam logic [31:0] ERASE = 32'h1 << CTL_ERASE;
  localparam logic [31:0] LATCH = 32'h1 << CTL_LATCH;
  logic mclk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic por_resetn_i = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic arvalid = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, force_nop, stall, nop_b;
  logic arr_rd, arr_erase, arr_prog, arr_latch, arr_cfg;
  logic [1:0] bresp, rresp, last_resp;
  logic [31:0] rdata;
  logic [14:0] arr_addr;
  logic [13:0] arr_rdata, arr_wdata;
  logic [31:0] seed = 32'h9206;
  int n_fail = 0;
  int check_count = 0;

  always #50 mclk_i = ~mclk_i;

  fspc_top #(.PROG_CYCLES(PC)) dut_u (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .por_resetn_i(por_resetn_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(1'b1), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(1'b1), .force_nop_o(force_nop),
    .stall_o(stall), .arr_addr_o(arr_addr), .arr_rd_o(arr_rd), .arr_rdata_i(arr_rdata),
    .arr_erase_o(arr_erase), .arr_prog_o(arr_prog), .arr_latch_o(arr_latch),
    .arr_cfg_sel_o(arr_cfg), .arr_wdata_o(arr_wdata)
  );

  fspc_array_model model_u (
    .mclk_i(mclk_i), .arr_addr_i(arr_addr), .arr_rd_i(arr_rd), .arr_rdata_o(arr_rdata)
  );

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  function automatic logic [13:0] word_of(input logic [14:0] a);
    return a[13:0] ^ 14'h2C3A;
  endfunction : word_of

  task automatic tally_and_finish();
    $display("checks %0d, failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  // Response ready is tied high, so a write ends at the edge bvalid is seen
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge mclk_i);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    last_resp = bresp;
    nop_b = force_nop;
    check(last_resp, (a > OFS_KEY) ? RESP_SLVERR : RESP_OKAY);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge mclk_i);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    last_resp = rresp;
  endtask : rd

  task automatic set_addr(input logic [14:0] a);
    wr(OFS_ADDR_LOW, {24'h0, a[7:0]});
    wr(OFS_ADDR_HIGH, {25'h0, a[14:8]});
  endtask : set_addr

  task automatic unlock_go(input logic [31:0] mode, input logic [7:0] k1, input logic [7:0] k2);
    wr(OFS_CONTROL, mode);
    wr(OFS_KEY, {24'h0, k1});
    wr(OFS_KEY, {24'h0, k2});
    wr(OFS_CONTROL, mode | GO);
  endtask : unlock_go

  // Kind: 0 read, 1 erase, 2 program, 3 latch load, 4 refused
  task automatic op_check(input int kind, input logic [14:0] a);
    int n;
    logic [31:0] d;
    logic [13:0] w;
    check(nop_b, kind != 0 && kind != 4);
    @(posedge mclk_i);
    check(force_nop, kind != 4);
    check(arr_rd, kind == 0);
    @(posedge mclk_i);
    check({arr_erase, arr_prog, arr_latch}, {kind == 1, kind == 2, kind == 3});
    if (kind == 1) check(arr_addr, {a[14:5], 5'h00});
    n = 0;
    while (stall && n < 100) begin
      n++;
      @(posedge mclk_i);
    end
    check(n, (kind == 1 || kind == 2) ? PC : 0);
    check(force_nop, 0);
    rd(OFS_CONTROL, d);
    check(d[CTL_GO] | d[CTL_FETCH], 0);
    if (kind == 0) begin
      w = word_of(a);
      rd(OFS_DATA_LOW, d);
      check(d, {24'h0, w[7:0]});
      rd(OFS_DATA_HIGH, d);
      check(d, {26'h0, w[13:8]});
    end
  endtask : op_check

  initial begin
    repeat (50000) @(posedge mclk_i);
    n_fail++;
    tally_and_finish();
  end

  initial begin
    logic [31:0] d;
    logic [14:0] a;
    logic [13:0] w;
    repeat (20) @(posedge mclk_i);
    resetn_i <= 1'b1;
    por_resetn_i <= 1'b1;
    @(posedge mclk_i);
    rd(OFS_CONTROL, d);
    check(d, 0);
    wr(OFS_KEY, {24'h0, KEY_FIRST});
    rd(OFS_KEY, d);
    check(d, 0);
    rd(8'h18, d);
    check(d, 0);
    check(last_resp, RESP_SLVERR);
    wr(8'h1C, 32'h1);
    wr(OFS_CONTROL, 32'h1 << CTL_CFGSEL);
    check(arr_cfg, 1'b1);
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      a = seed[14:0];
      set_addr(a);
      wr(OFS_CONTROL, FETCH);
      check(arr_cfg, 1'b0);
      op_check(0, a);
    end
    // Software data write replaces the captured low byte; high byte untouched
    w = word_of(a);
    wr(OFS_DATA_LOW, {24'h0, seed[22:15]});
    rd(OFS_DATA_LOW, d);
    check(d, {24'h0, seed[22:15]});
    rd(OFS_DATA_HIGH, d);
    check(d, {26'h0, w[13:8]});
    check(arr_wdata, {w[13:8], seed[22:15]});
    for (int k = 1; k < 4; k++) begin
      seed = xs(seed);
      a = seed[14:0];
      set_addr(a);
      unlock_go(k == 1 ? PERMIT | ERASE : k == 2 ? PERMIT : PERMIT | LATCH,
                KEY_FIRST, KEY_SECOND);
      op_check(k, a);
      if (k == 1) begin
        wr(OFS_CONTROL, FETCH);
        op_check(0, a);
      end
    end
    unlock_go(PERMIT | ERASE, KEY_SECOND, KEY_FIRST);
    op_check(4, a);
    unlock_go(ERASE, KEY_FIRST, KEY_SECOND);
    op_check(4, a);
    wr(OFS_CONTROL, PERMIT | ERASE);
    wr(OFS_KEY, {24'h0, KEY_FIRST});
    wr(OFS_KEY, {24'h0, KEY_SECOND});
    wr(OFS_DATA_LOW, 32'h0);
    wr(OFS_CONTROL, PERMIT | ERASE | GO);
    op_check(4, a);
    // Reset in mid-erase must leave a trace for software
    unlock_go(PERMIT | ERASE, KEY_FIRST, KEY_SECOND);
    repeat (4) @(posedge mclk_i);
    resetn_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    resetn_i <= 1'b1;
    @(posedge mclk_i);
    check(stall, 0);
    rd(OFS_CONTROL, d);
    check(d, ABORT);
    por_resetn_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    por_resetn_i <= 1'b1;
    @(posedge mclk_i);
    rd(OFS_CONTROL, d);
    check(d, 0);
    tally_and_finish();
  end
endmodule : test_flash_self_program_ctrl
